// ### tis_top.sv
// Purpose: 8-bit timer with prescaler and interrupt sequencing for the core
// Assumes: Core pulses insn_done_i at each instruction boundary
// Notes: All pins sampled on clk_i; slow sources arrive as enable pulses
//
// What this block does
// - Software loads an 8-bit counter that counts down when clocked.
// - Reaching zero sets the timer request flag, control bit 7.
// - Timer mask bit 6 or core mask flag blocks timer servicing.
// - Timer service stacks state then fetches vector FFF8/FFF9, except on a wake from halt, which fetches at once.
// - Software picks count source: timer pin, fast clock or slow clock.
// - Internal sources count only while the timer pin is high.
// - Slow clock counts in halt; fast clock needs main oscillator running.
// - Pin and slow clock counting stays safe against register access.
// - 7-bit prescaler before counter, set by low three control bits.
// - Counter wraps past zero; reads show live count, undisturbed.
// - Reset sets prescaler and counter to ones, clears request, sets mask.
// - Software only clears request by writing zero; mask freely written.
// - Acceptance stacks state (not for the reset pin or a wake from halt), sets core mask, loads vector, runs service.
// - Six sources by fixed priority, vectors FFFE down to FFF4.
// - Mask clear acts after next instruction; mask set acts at once.
// - Clearing a peripheral mask makes its request acceptable at once.
// - In halt, peripherals run and an interrupt wakes and vectors.
// - In standby no request is acknowledged, not even the reset pin.
// - A request met by the core mask stays pending until cleared.
`timescale 1ns/1ps
`default_nettype none
module tis_top
  import tis_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Count sources
  input wire logic timer_pin_i,
  input wire logic fast_cycle_clock_i,
  input wire logic slow_crystal_clock_i,
  input wire logic main_oscillator_run_i,
  // Core events
  input wire logic insn_done_i,
  input wire logic mask_clear_i,
  input wire logic mask_set_i,
  input wire logic return_from_trap_i,
  input wire logic sw_trap_i,
  input wire logic halt_req_i,
  input wire logic standby_i,
  // Other interrupt sources
  input wire logic reset_pin_i,
  input wire logic ext_irq_i,
  input wire logic adc_done_req_i,
  input wire logic time_base_req_i,
  // Sequencer outputs
  output logic irq_accept_o,
  output logic [15:0] irq_vector_o,
  output logic push_state_o,
  output logic irq_mask_o,
  output logic cpu_halted_o,
  output logic timer_req_o
);
  // ***********************************
  // Bus decode
  // ***********************************
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_en = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
  wire wr_tdata = wr_en && (wb_adr_i == ADR_TDATA);
  wire wr_tctrl = wr_en && (wb_adr_i == ADR_TCTRL);

  // ***********************************
  // Timer state
  // ***********************************
  logic [7:0] cnt_reg;
  logic req_reg;
  logic mask_reg;
  tis_src_t src_reg;
  logic [2:0] ps_reg;
  logic pin_q_reg;
  logic tick;
  wire pin_rise = timer_pin_i && !pin_q_reg;
  // Fast clock is only live while the main oscillator runs
  wire fast_ok = fast_cycle_clock_i && main_oscillator_run_i;
  wire src_pulse =
    (src_reg == SRC_PIN) ? pin_rise :
    (src_reg == SRC_FAST) ? (fast_ok && timer_pin_i) :
    (src_reg == SRC_SLOW) ? (slow_crystal_clock_i && timer_pin_i) :
    1'b0;
  wire hit_zero = tick && (cnt_reg == 8'h01);
  wire clr_req = wr_tctrl && !wb_dat_i[TC_REQ_BIT];

  tis_prescaler u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pulse_i(src_pulse),
    .sel_i(ps_reg),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i) begin
    // Edge memory keeps the pin source to one pulse per rise
    pin_q_reg <= rst_i ? 1'b0 : timer_pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= TDATA_RST;
    end else if (wr_tdata) begin
      cnt_reg <= wb_dat_i[7:0];
    end else if (tick) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_reg <= 1'b0;
    end else if (hit_zero) begin
      req_reg <= 1'b1;
    end else if (clr_req) begin
      req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= 1'b1;
      src_reg <= tis_src_t'(TSRC_RST);
      ps_reg <= TPS_RST;
    end else if (wr_tctrl) begin
      mask_reg <= wb_dat_i[TC_MASK_BIT];
      src_reg <= tis_src_t'(wb_dat_i[TC_SRC_LSB +: 2]);
      ps_reg <= wb_dat_i[TC_PS_LSB +: 3];
    end
  end

  // ***********************************
  // Request gathering and arbitration
  // ***********************************
  tis_state_t st_reg;
  tis_state_t st_next;
  logic swi_reg;
  logic i_flag_reg;
  logic clr_hold_reg;
  logic [2:0] bytes_reg;
  logic [15:0] vec_hold_reg;
  logic [2:0] idx_hold_reg;
  logic hit;
  logic [2:0] idx;
  logic [15:0] vec;
  tis_req_t req;
  assign req.reset_pin = reset_pin_i;
  assign req.swi = swi_reg;
  assign req.port_write_strobe_enable = ext_irq_i;
  // Timer mask taken live, so clearing it frees a pending request at once
  assign req.timer = req_reg && !mask_reg;
  assign req.adc = adc_done_req_i;
  assign req.tb = time_base_req_i;

  tis_arbiter u_arb (
    .req_i(req),
    .hit_o(hit),
    .idx_o(idx),
    .vec_o(vec)
  );

  wire no_mask = (idx == IDX_RESET) || (idx == IDX_SWI);
  // Set mask blocks the very next boundary; cleared mask waits one more
  wire core_block = i_flag_reg || clr_hold_reg || mask_set_i;
  wire may_take = hit && (no_mask || !core_block);
  wire take_now = may_take && (insn_done_i || (req.reset_pin));

  // ***********************************
  // Sequencer
  // ***********************************
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_RUN: begin
        if (standby_i) begin
          st_next = ST_STANDBY;
        end else if (take_now) begin
          st_next = (idx == IDX_RESET) ? ST_VECTOR : ST_STACK;
        end else if (halt_req_i) begin
          st_next = ST_HALT;
        end
      end
      ST_STACK: begin
        if (bytes_reg == STACK_BYTES - 3'h1) begin
          st_next = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        st_next = ST_RUN;
      end
      ST_HALT: begin
        if (standby_i) begin
          st_next = ST_STANDBY;
        end else if (may_take) begin
          st_next = ST_VECTOR;
        end
      end
      ST_STANDBY: begin
        if (!standby_i) begin
          st_next = ST_RUN;
        end
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  wire capture = ((st_reg == ST_RUN) && take_now && !standby_i) ||
    ((st_reg == ST_HALT) && may_take && !standby_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_RUN;
      bytes_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      bytes_reg <= (st_reg == ST_STACK) ? bytes_reg + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_hold_reg <= VEC_TOP;
      idx_hold_reg <= IDX_RESET;
    end else if (capture) begin
      vec_hold_reg <= vec;
      idx_hold_reg <= idx;
    end
  end

  // Trap stays pending until its vector is issued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swi_reg <= 1'b0;
    end else if (sw_trap_i) begin
      swi_reg <= 1'b1;
    end else if (st_reg == ST_VECTOR && idx_hold_reg == IDX_SWI) begin
      swi_reg <= 1'b0;
    end
  end

  // Acceptance wins over any mask change in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      i_flag_reg <= 1'b1;
      clr_hold_reg <= 1'b0;
    end else begin
      if (st_reg == ST_VECTOR) begin
        i_flag_reg <= 1'b1;
      end else if (mask_set_i) begin
        i_flag_reg <= 1'b1;
      end else if (mask_clear_i || return_from_trap_i) begin
        i_flag_reg <= 1'b0;
      end
      if (mask_clear_i) begin
        clr_hold_reg <= 1'b1;
      end else if (insn_done_i) begin
        clr_hold_reg <= 1'b0;
      end
    end
  end

  // ***********************************
  // Registered outputs
  // ***********************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_accept_o <= 1'b0;
      irq_vector_o <= VEC_TOP;
      push_state_o <= 1'b0;
      irq_mask_o <= 1'b1;
      cpu_halted_o <= 1'b0;
      timer_req_o <= 1'b0;
    end else begin
      irq_accept_o <= (st_reg == ST_VECTOR);
      if (st_reg == ST_VECTOR) begin
        irq_vector_o <= vec_hold_reg;
      end
      push_state_o <= (st_reg == ST_STACK);
      irq_mask_o <= (st_reg == ST_VECTOR) || (i_flag_reg && !(mask_clear_i
        || return_from_trap_i)) || mask_set_i;
      cpu_halted_o <= (st_next == ST_HALT) || (st_next == ST_STANDBY);
      timer_req_o <= req.timer;
    end
  end

  // ***********************************
  // Bus slave
  // ***********************************
  // Reads return the live count; nothing in the read path touches it
  always_comb begin
    rdat_next = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_TDATA: begin
        rdat_next[7:0] = cnt_reg;
      end
      ADR_TCTRL: begin
        rdat_next[TC_REQ_BIT] = req_reg;
        rdat_next[TC_MASK_BIT] = mask_reg;
        rdat_next[TC_SRC_LSB +: 2] = src_reg;
        rdat_next[TC_PS_LSB +: 3] = ps_reg;
      end
      ADR_CORE_STAT: begin
        rdat_next[7] = i_flag_reg;
        rdat_next[6] = clr_hold_reg;
        rdat_next[5] = hit;
        rdat_next[2:0] = st_reg;
      end
      default: begin
        rdat_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      rdat_reg <= rdat_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ***********************************
  // Checks
  // ***********************************
  property p_req_on_zero;
    @(posedge clk_i) disable iff (rst_i) hit_zero |=> req_reg && cnt_reg == 8'h00;
  endproperty
  a_req_on_zero: assert property (p_req_on_zero) else $error("Zero did not set request");
  property p_wrap;
    @(posedge clk_i) disable iff (rst_i) tick && !wr_tdata && cnt_reg == 8'h00 |=> cnt_reg == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Counter did not wrap");
  property p_reset_vals;
    @(posedge clk_i) rst_i |=> cnt_reg == TDATA_RST && !req_reg && mask_reg;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Bad timer reset state");
  property p_one_no_set;
    @(posedge clk_i) disable iff (rst_i)
      wr_tctrl && wb_dat_i[TC_REQ_BIT] && !req_reg && !hit_zero |=> !req_reg;
  endproperty
  a_one_no_set: assert property (p_one_no_set) else $error("Software set the request");
  property p_mask_blocks;
    @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_RUN && !standby_i && core_block && !no_mask |=> st_reg != ST_STACK;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("Masked request taken");
  property p_standby;
    @(posedge clk_i) disable iff (rst_i) st_reg == ST_STANDBY |=> ##1 !irq_accept_o;
  endproperty
  a_standby: assert property (p_standby) else $error("Accept in standby");
  property p_stack;
    @(posedge clk_i) disable iff (rst_i)
      $rose(st_reg == ST_STACK) |-> ##1 push_state_o [*5] ##1 irq_accept_o;
  endproperty
  a_stack: assert property (p_stack) else $error("Bad stacking sequence");
  property p_accept_mask;
    @(posedge clk_i) disable iff (rst_i) irq_accept_o |-> irq_mask_o && i_flag_reg;
  endproperty
  a_accept_mask: assert property (p_accept_mask) else $error("Mask not set on accept");
  property p_halt_wake;
    @(posedge clk_i) disable iff (rst_i)
      st_reg == ST_HALT && may_take && !standby_i |=> st_reg == ST_VECTOR ##1 irq_accept_o;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("Halt did not wake");
  c_timer_vec: cover property (@(posedge clk_i) irq_accept_o && irq_vector_o == VEC_TIMER);
  c_halt_wake: cover property (@(posedge clk_i) st_reg == ST_HALT ##1 st_reg == ST_VECTOR);
  c_wrap: cover property (@(posedge clk_i) tick && cnt_reg == 8'h00);
endmodule : tis_top
`default_nettype wire

// ### tis_pkg.sv
// Purpose: Shared constants and types of the timer and interrupt sequencer
// Assumes: One 125 MHz clock, classic Wishbone with 32-bit data
// Notes: Registers are 8 bits wide in the low byte of each word
package tis_pkg;
  // ***********************************
  // Register map and fields
  // ***********************************
  localparam logic [3:0] ADR_TDATA = 4'h0;
  localparam logic [3:0] ADR_TCTRL = 4'h4;
  localparam logic [3:0] ADR_CORE_STAT = 4'h8;
  localparam int TC_REQ_BIT = 7;
  localparam int TC_MASK_BIT = 6;
  localparam int TC_SRC_LSB = 4;
  localparam int TC_PS_LSB = 0;
  localparam logic [7:0] TDATA_RST = 8'hff;
  localparam logic [6:0] PRESC_RST = 7'h7f;
  localparam logic [1:0] TSRC_RST = 2'h0;
  localparam logic [2:0] TPS_RST = 3'h0;
  // ***********************************
  // Vectors and sequencing
  // ***********************************
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [15:0] VEC_TIMER = 16'hfff8;
  localparam logic [2:0] IDX_RESET = 3'h0;
  localparam logic [2:0] IDX_SWI = 3'h1;
  localparam logic [2:0] STACK_BYTES = 3'h5;
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_FAST = 2'b01,
    SRC_SLOW = 2'b10,
    SRC_OFF = 2'b11
  } tis_src_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STACK = 3'b001,
    ST_VECTOR = 3'b010,
    ST_HALT = 3'b011,
    ST_STANDBY = 3'b100
  } tis_state_t;
  // Highest priority in the top bit
  typedef struct packed {
    logic reset_pin;
    logic swi;
    logic port_write_strobe_enable;
    logic timer;
    logic adc;
    logic tb;
  } tis_req_t;
endpackage : tis_pkg

// ### tis_prescaler.sv
// Purpose: 7-bit prescaler turning source pulses into counter ticks
// Assumes: pulse_i is a one-cycle enable
// Notes: Field n divides by two to the power n
`timescale 1ns/1ps
`default_nettype none
module tis_prescaler
  import tis_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Count path
  input wire logic pulse_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [6:0] presc_reg;
  logic [6:0] mask;
  // ***********************************
  // Divider
  // ***********************************
  for (genvar i = 0; i < 7; i++) begin : g_mask
    assign mask[i] = (sel_i > 3'(i));
  end
  assign tick_o = pulse_i && ((presc_reg & mask) == 7'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg <= PRESC_RST;
    end else if (pulse_i) begin
      presc_reg <= presc_reg - 7'h01;
    end
  end
  property p_tick_from_pulse;
    @(posedge clk_i) disable iff (rst_i) tick_o |-> pulse_i && (presc_reg[0] == 1'b0 || sel_i == 3'h0);
  endproperty
  a_tick_from_pulse: assert property (p_tick_from_pulse) else $error("Tick without due pulse");
endmodule : tis_prescaler
`default_nettype wire

// ### tis_arbiter.sv
// Purpose: Fixed priority choice among six requests
// Assumes: Requests are levels
// Notes: Vector pairs step down by two bytes per priority
`timescale 1ns/1ps
`default_nettype none
module tis_arbiter
  import tis_pkg::*;
(
  // Requests
  input wire tis_req_t req_i,
  // Winner
  output logic hit_o,
  output logic [2:0] idx_o,
  output logic [15:0] vec_o
);
  function automatic logic [2:0] first_set(input logic [5:0] r);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (r[i]) begin
        k = 3'(5 - i);
      end
    end
    return k;
  endfunction : first_set
  assign hit_o = |req_i;
  assign idx_o = first_set(req_i);
  assign vec_o = VEC_TOP - {12'h000, idx_o, 1'b0};
  // Checked on the fall, so the sampled values are those of the high phase
  property p_reset_first;
    @(negedge req_i.reset_pin) req_i.reset_pin |-> idx_o == IDX_RESET && vec_o == VEC_TOP;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("Reset pin not first");
endmodule : tis_arbiter
`default_nettype wire

// ### tis_core_model.sv
// Purpose: Behavioural core that paces instruction boundaries
// Assumes: gap_i of two or more cycles between boundaries
// Notes: Counts stacked bytes and records each accepted vector
`timescale 1ns/1ps
`default_nettype none
module tis_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pacing and requests
  input wire logic [3:0] gap_i,
  input wire logic halted_i,
  input wire logic clr_i,
  input wire logic set_i,
  // Sequencer side
  input wire logic accept_i,
  input wire logic push_i,
  input wire logic [15:0] vector_i,
  output logic insn_done_o,
  output logic mask_clear_o,
  output logic mask_set_o,
  // Observations
  output logic [7:0] acc_cnt_o,
  output logic [15:0] last_vec_o,
  output logic [3:0] last_push_o,
  output logic [7:0] clr_gap_o
);
  logic [3:0] cnt_reg;
  logic [3:0] push_reg;
  logic [7:0] since_reg;
  logic clr_reg;
  logic set_reg;
  wire logic wrap = cnt_reg >= gap_i - 4'h1;
  // No boundaries while halted, as a stopped core executes nothing
  wire logic tick = wrap && !halted_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
      push_reg <= 4'h0;
      since_reg <= 8'h0;
      clr_reg <= 1'b0;
      set_reg <= 1'b0;
      insn_done_o <= 1'b0;
      mask_clear_o <= 1'b0;
      mask_set_o <= 1'b0;
      acc_cnt_o <= 8'h0;
      last_vec_o <= 16'h0;
      last_push_o <= 4'h0;
      clr_gap_o <= 8'h0;
    end else begin
      cnt_reg <= wrap ? 4'h0 : cnt_reg + 4'h1;
      insn_done_o <= tick;
      mask_clear_o <= tick && (clr_reg || clr_i);
      mask_set_o <= tick && (set_reg || set_i);
      clr_reg <= !tick && (clr_reg || clr_i);
      set_reg <= !tick && (set_reg || set_i);
      since_reg <= mask_clear_o ? 8'h1 : since_reg + 8'h1;
      push_reg <= accept_i ? 4'h0 : push_reg + {3'h0, push_i};
      if (accept_i) begin
        acc_cnt_o <= acc_cnt_o + 8'h1;
        last_vec_o <= vector_i;
        last_push_o <= push_reg;
        clr_gap_o <= since_reg;
      end
    end
  end
endmodule : tis_core_model
`default_nettype wire

// ### tis_top_tb.sv
// Purpose: Self-checking bench of the timer and interrupt sequencer
// Assumes: Core model paces boundaries; bench drives the rest
// Notes: Plain register writes only, never read-modify-write
`timescale 1ns/1ps
`default_nettype none
module tis_top_tb;
  import tis_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, osc, stby, port_write_strobe_enable, adc, tbase;
  logic [3:0] adr, gap, lpush;
  logic [31:0] wdat, rdat;
  logic [2:0] cs;
  logic [5:0] ev;
  logic insn, mclr, mset, acc, push, imask, halted, treq;
  logic [15:0] vec, lvec;
  logic [7:0] acnt, cgap;
  int num_errors = 0;
  int comparisons = 0;

  tis_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_pin_i(cs[0]), .fast_cycle_clock_i(cs[1]),
    .slow_crystal_clock_i(cs[2]), .main_oscillator_run_i(osc), .insn_done_i(insn),
    .mask_clear_i(mclr), .mask_set_i(mset), .return_from_trap_i(ev[0]),
    .sw_trap_i(ev[1]), .halt_req_i(ev[3]), .standby_i(stby), .reset_pin_i(ev[2]),
    .ext_irq_i(port_write_strobe_enable), .adc_done_req_i(adc), .time_base_req_i(tbase),
    .irq_accept_o(acc), .irq_vector_o(vec), .push_state_o(push), .irq_mask_o(imask),
    .cpu_halted_o(halted), .timer_req_o(treq));
  tis_core_model core (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .halted_i(halted),
    .clr_i(ev[4]), .set_i(ev[5]), .accept_i(acc), .push_i(push), .vector_i(vec),
    .insn_done_o(insn), .mask_clear_o(mclr), .mask_set_o(mset), .acc_cnt_o(acnt),
    .last_vec_o(lvec), .last_push_o(lpush), .clr_gap_o(cgap));

  // ***********************************
  // Tasks
  // ***********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    // Read data taken at the very edge that sees ack high
    q = rdat;
    if (n == 20) chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  // Two toggles give one pulse, or one rising edge on the pin
  task automatic pls(input int k, input int n);
    repeat (n) begin
      cs[k] <= ~cs[k];
      @(posedge clk_i);
      cs[k] <= ~cs[k];
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : pls
  task automatic evp(input int k);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
    @(posedge clk_i);
  endtask : evp
  task automatic wacc(input logic [15:0] v, input logic [3:0] p);
    logic [7:0] a0;
    int n;
    a0 = acnt;
    n = 0;
    while (acnt == a0 && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk({24'h0, acnt - a0}, 32'h1);
    chk({16'h0, lvec}, {16'h0, v});
    chk({28'h0, lpush}, {28'h0, p});
  endtask : wacc
  task automatic noacc(input int n);
    logic [7:0] a0;
    a0 = acnt;
    repeat (n) @(posedge clk_i);
    chk({24'h0, acnt}, {24'h0, a0});
  endtask : noacc
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ***********************************
  // Clock, watchdog and tests
  // ***********************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
  initial begin
    {cyc, stb, we, osc, stby, port_write_strobe_enable, adc, tbase} = 8'h00;
    adr = 4'h0;
    wdat = 32'h0;
    cs = 3'h0;
    ev = 6'h00;
    gap = 4'h3;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_TDATA, 8'hff);
    rd(ADR_TCTRL, 8'h40);
    rd(4'hc, 8'h00);
    rd(ADR_CORE_STAT, 8'h80);
    $display("reset values done");
    wr(ADR_TDATA, 8'h03);
    pls(0, 3);
    rd(ADR_TDATA, 8'h00);
    rd(ADR_TCTRL, 8'hc0);
    chk({31'h0, treq}, 32'h0);
    wr(ADR_TCTRL, 8'hc0);
    rd(ADR_TCTRL, 8'hc0);
    wr(ADR_TCTRL, 8'h60);
    rd(ADR_TCTRL, 8'h60);
    pls(2, 2);
    rd(ADR_TDATA, 8'h00);
    cs[0] <= 1'b1;
    pls(2, 1);
    rd(ADR_TDATA, 8'hff);
    rd(ADR_TDATA, 8'hff);
    $display("count and flags done");
    wr(ADR_TCTRL, 8'h62);
    wr(ADR_TDATA, 8'h0a);
    pls(2, 8);
    rd(ADR_TDATA, 8'h08);
    wr(ADR_TCTRL, 8'h67);
    wr(ADR_TDATA, 8'h05);
    pls(2, 128);
    rd(ADR_TDATA, 8'h04);
    wr(ADR_TCTRL, 8'h50);
    wr(ADR_TDATA, 8'h06);
    pls(1, 3);
    rd(ADR_TDATA, 8'h06);
    osc <= 1'b1;
    pls(1, 3);
    rd(ADR_TDATA, 8'h03);
    wr(ADR_TCTRL, 8'h70);
    pls(2, 2);
    rd(ADR_TDATA, 8'h03);
    $display("sources and prescaler done");
    wr(ADR_TCTRL, 8'h20);
    wr(ADR_TDATA, 8'h01);
    pls(2, 1);
    chk({31'h0, treq}, 32'h1);
    noacc(30);
    evp(0);
    wacc(VEC_TIMER, 4'h5);
    chk({31'h0, imask}, 32'h1);
    wr(ADR_TCTRL, 8'h60);
    port_write_strobe_enable <= 1'b1;
    adc <= 1'b1;
    tbase <= 1'b1;
    evp(0);
    wacc(16'hfffa, 4'h5);
    port_write_strobe_enable <= 1'b0;
    evp(0);
    wacc(16'hfff6, 4'h5);
    adc <= 1'b0;
    evp(0);
    wacc(16'hfff4, 4'h5);
    tbase <= 1'b0;
    evp(1);
    wacc(16'hfffc, 4'h5);
    evp(2);
    wacc(VEC_TOP, 4'h0);
    $display("priority done");
    evp(0);
    stby <= 1'b1;
    port_write_strobe_enable <= 1'b1;
    evp(2);
    noacc(40);
    chk({31'h0, halted}, 32'h1);
    stby <= 1'b0;
    wacc(16'hfffa, 4'h5);
    port_write_strobe_enable <= 1'b0;
    evp(0);
    evp(3);
    repeat (4) @(posedge clk_i);
    chk({31'h0, halted}, 32'h1);
    rd(ADR_CORE_STAT, 8'h03);
    wr(ADR_TDATA, 8'h02);
    pls(2, 1);
    rd(ADR_TDATA, 8'h01);
    tbase <= 1'b1;
    wacc(16'hfff4, 4'h0);
    chk({31'h0, halted}, 32'h0);
    tbase <= 1'b0;
    $display("standby and halt done");
    gap <= 4'h5;
    port_write_strobe_enable <= 1'b1;
    ev <= 6'h21;
    @(posedge clk_i);
    ev <= 6'h00;
    noacc(40);
    evp(4);
    wacc(16'hfffa, 4'h5);
    chk({24'h0, cgap}, 32'h11);
    port_write_strobe_enable <= 1'b0;
    $display("mask timing done");
    end_sim();
  end
endmodule : tis_top_tb
`default_nettype wire
